// ==== verilog/tm_irq_defs.vh ====
// register map, field positions and reset values of the timer match interrupt block
`ifndef TIMER_IRQ_DEFS_VH
`define TIMER_IRQ_DEFS_VH
`define ADDR_W          8
`define OFF_CTRL        8'h00
`define OFF_FLAGS       8'h04
`define OFF_STACK       8'h08
`define OFF_VECTOR      8'h0C
`define CTRL_GIE_BIT    0
`define CTRL_MFE_BIT    1
`define CTRL_AE_BIT     2
`define CTRL_PE_BIT     3
`define FLG_AF_BIT      0
`define FLG_PF_BIT      1
`define FLG_MFF_BIT     2
`define CTRL_RST        4'h0
`define FLAGS_RST       3'h0
`define STACK_DEPTH     4'h4
`define PC_W            12
`define MF_VECTOR_RST   12'h008
`endif

// ==== verilog/timer_match_interrupt_wakeup.v ====
// timer comparator match interrupts, multi-function grouping, wake-up and irq entry/return
//
// Design decisions made here: the APB slave port and the register addresses.
`timescale 1ns/1ps
`include "tm_irq_defs.vh"
// Notes on behaviour
// - two timer sources share one multi-function vector
// - each match sets own flag; own enable
// - call vector when global, multi-function and pending source's own enable set, stack free
// - entry clears global enable, multi-function flag
// - rising request flag raises wake-up, clock-free
// - enables never gate the wake-up path
// - source flags stay set until software clears them; servicing clears only multi-function flag
// - only program counter pushed on entry
// - return-from-irq sets global enable; plain return not
// - multi-function flag set when source flag sets
module timer_match_interrupt_wakeup
(
    input  wire                REF_CLK,
    input  wire                RST_N,
    input  wire                PSEL,
    input  wire                PENABLE,
    input  wire                PWRITE,
    input  wire [7:0]          PADDR,
    input  wire [31:0]         PWDATA,
    output wire [31:0]         PRDATA,
    output wire                PREADY,
    output wire                PSLVERR,
    input  wire                MATCH_A,
    input  wire                MATCH_P,
    input  wire                INSTR_DONE,
    input  wire [`PC_W-1:0]    NEXT_PC,
    input  wire                CALL_PUSH,
    input  wire                RET_POP,
    input  wire                RETURN_FROM_IRQ,
    output wire                IRQ_CALL,
    output wire [`PC_W-1:0]    IRQ_VECTOR,
    output wire [`PC_W-1:0]    PUSH_PC,
    output wire [`PC_W-1:0]    RETURN_PC,
    output wire                STACK_FULL,
    output wire                WAKEUP
);
    reg              rst_s1_r;
    reg              rst_s2_r;
    wire             rst_n = rst_s2_r;
    reg  [3:0]       ctrl_r;
    reg  [2:0]       flags_r;
    reg  [2:0]       flags_nxt;
    reg  [31:0]      prdata_r;
    reg              wake_r;
    reg  [`PC_W-1:0] stack_r [0:3];
    reg  [2:0]       sp_r;
    wire             wr;
    wire             rd;
    wire             serv;
    wire             ret_any;
    wire             push_any;
    wire             src_req;
    wire             gates_open;
    wire [2:0]       rise;
    genvar           g;

    function automatic hit;
        input [7:0] a;
        input [7:0] off;
        begin
            hit = (a == off);
        end
    endfunction

    function automatic mapped;
        input [7:0] a;
        begin
            mapped = hit(a, `OFF_CTRL) | hit(a, `OFF_FLAGS)
                     | hit(a, `OFF_STACK) | hit(a, `OFF_VECTOR);
        end
    endfunction

    always @(posedge REF_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            rst_s1_r <= 1'b0;
            rst_s2_r <= 1'b0;
        end
        else
        begin
            rst_s1_r <= 1'b1;
            rst_s2_r <= rst_s1_r;
        end
    end

    assign wr      = PSEL & PENABLE & PWRITE;
    assign rd      = PSEL & ~PWRITE;
    assign PREADY  = 1'b1;
    assign PSLVERR = PSEL & PENABLE & ~mapped(PADDR);
    assign STACK_FULL = ({1'b0, sp_r} == `STACK_DEPTH);

    // a source counts only when its own flag and its own enable are set
    assign src_req = (flags_r[`FLG_AF_BIT] & ctrl_r[`CTRL_AE_BIT])
                     | (flags_r[`FLG_PF_BIT] & ctrl_r[`CTRL_PE_BIT]);
    assign gates_open = ctrl_r[`CTRL_GIE_BIT] & ctrl_r[`CTRL_MFE_BIT] & ~STACK_FULL;
    // service only at an instruction boundary, so the pushed pc is clean
    assign serv = INSTR_DONE & gates_open & flags_r[`FLG_MFF_BIT] & src_req;
    assign IRQ_CALL   = serv;
    assign IRQ_VECTOR = `MF_VECTOR_RST;
    assign PUSH_PC    = NEXT_PC;
    assign ret_any    = (RET_POP | RETURN_FROM_IRQ) & (sp_r != 3'h0);
    assign push_any   = (serv | CALL_PUSH) & ~STACK_FULL;
    assign RETURN_PC  = (sp_r == 3'h0) ? {`PC_W{1'b0}} : stack_r[sp_r[1:0] - 2'h1];

    always @*
    begin
        flags_nxt = flags_r;
        if (wr && hit(PADDR, `OFF_FLAGS))
            flags_nxt = PWDATA[2:0];
        if (serv)
            flags_nxt[`FLG_MFF_BIT] = 1'b0;
        // hardware sets win over software clears and over servicing
        if (MATCH_A)
            flags_nxt[`FLG_AF_BIT] = 1'b1;
        if (MATCH_P)
            flags_nxt[`FLG_PF_BIT] = 1'b1;
        if ((flags_nxt[`FLG_AF_BIT] & ~flags_r[`FLG_AF_BIT])
            | (flags_nxt[`FLG_PF_BIT] & ~flags_r[`FLG_PF_BIT]))
            flags_nxt[`FLG_MFF_BIT] = 1'b1;
    end

    always @(posedge REF_CLK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            flags_r <= `FLAGS_RST;
        end
        else
        begin
            flags_r <= flags_nxt;
        end
    end

    // software write first; entry and return then override the global enable
    always @(posedge REF_CLK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl_r <= `CTRL_RST;
        end
        else
        begin
            if (wr && hit(PADDR, `OFF_CTRL))
                ctrl_r <= PWDATA[3:0];
            if (serv)
                ctrl_r[`CTRL_GIE_BIT] <= 1'b0;
            else if (RETURN_FROM_IRQ && ret_any)
                ctrl_r[`CTRL_GIE_BIT] <= 1'b1;
        end
    end

    // push beats pop when both land in one cycle
    always @(posedge REF_CLK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sp_r <= 3'h0;
        end
        else if (push_any)
        begin
            sp_r <= sp_r + 3'h1;
        end
        else if (ret_any)
        begin
            sp_r <= sp_r - 3'h1;
        end
    end

    // read data taken in the setup cycle, so the access phase needs no wait
    always @(posedge REF_CLK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            prdata_r <= 32'h0;
        end
        else if (rd && !PENABLE)
        begin
            case (1'b1)
                hit(PADDR, `OFF_CTRL):   prdata_r <= {28'h0, ctrl_r};
                hit(PADDR, `OFF_FLAGS):  prdata_r <= {29'h0, flags_r};
                hit(PADDR, `OFF_STACK):  prdata_r <= {29'h0, sp_r};
                hit(PADDR, `OFF_VECTOR): prdata_r <= {20'h0, IRQ_VECTOR};
                default:                 prdata_r <= 32'h0;
            endcase
        end
    end

    // stack holds the pc only; no other state is saved
    generate
        for (g = 0; g < 4; g = g + 1)
        begin : stk
            always @(posedge REF_CLK)
            begin
                if (push_any && sp_r[1:0] == g[1:0])
                    stack_r[g] <= NEXT_PC;
            end
        end
    endgenerate

    // wake-up is a rising edge on any flag, never masked by enables
    // comb term covers the rising cycle, the register the cycle after it
    assign rise = flags_nxt & ~flags_r;
    always @(posedge REF_CLK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wake_r <= 1'b0;
        end
        else
        begin
            wake_r <= |rise;
        end
    end
    // a source set high before sleep can never rise, so never wakes
    assign WAKEUP = wake_r | (|rise);
    assign PRDATA = prdata_r;
endmodule

// ==== sim/tmiw_chk.sv ====
// port assertions for the timer match irq block
`timescale 1ns/1ps
module tmiw_chk
(
    input        REF_CLK,
    input        RST_N,
    input        PSEL,
    input        PENABLE,
    input  [7:0] PADDR,
    input        PSLVERR,
    input        INSTR_DONE,
    input [11:0] NEXT_PC,
    input        IRQ_CALL,
    input [11:0] IRQ_VECTOR,
    input [11:0] PUSH_PC,
    input        STACK_FULL,
    input        WAKEUP
);
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!RST_N);
    sequence s_one; IRQ_CALL ##1 !IRQ_CALL; endsequence
    property p_bnd; IRQ_CALL |-> INSTR_DONE; endproperty
    a_bnd: assert property (p_bnd) else $error("call off boundary");
    property p_ful; STACK_FULL |-> !IRQ_CALL; endproperty
    a_ful: assert property (p_ful) else $error("call on full");
    property p_one; IRQ_CALL |-> s_one; endproperty
    a_one: assert property (p_one) else $error("call twice");
    property p_pc; IRQ_CALL |-> PUSH_PC == NEXT_PC; endproperty
    a_pc: assert property (p_pc) else $error("push pc");
    property p_vec; IRQ_CALL |-> IRQ_VECTOR == 12'h008; endproperty
    a_vec: assert property (p_vec) else $error("vector");
    property p_wk; $rose(WAKEUP) |=> WAKEUP; endproperty
    a_wk: assert property (p_wk) else $error("short wake");
    property p_ok; PSEL && PENABLE && PADDR == 8'h04 |-> !PSLVERR; endproperty
    a_ok: assert property (p_ok) else $error("flags refused");
    property p_hi; PSEL && PENABLE && PADDR > 8'h0C |-> PSLVERR; endproperty
    a_hi: assert property (p_hi) else $error("no slverr");
endmodule

// ==== sim/cpu_seq_model.sv ====
// cpu sequencer stand-in
`timescale 1ns/1ps
module cpu_seq_model
(
    input             clk,
    input             run,
    output            at_boundary,
    output reg [11:0] pc_r = 12'h100
);
    assign at_boundary = run;
    always @(posedge clk)
        pc_r <= pc_r + 12'h001;
endmodule

// ==== sim/timer_match_interrupt_wakeup_tb_top.sv ====
// bench for the timer match irq block
`timescale 1ns/1ps
module timer_match_interrupt_wakeup_tb_top;
    reg         REF_CLK = 0, RST_N = 0, PSEL = 0, PENABLE = 0, PWRITE = 0;
    reg         MATCH_A = 0, MATCH_P = 0, RETURN_FROM_IRQ = 0, run = 0, err;
    reg  [7:0]  PADDR = 0;
    reg  [31:0] PWDATA = 0, rdat;
    reg  [11:0] pc;
    wire [31:0] PRDATA;
    wire        PREADY, PSLVERR, IRQ_CALL, STACK_FULL, WAKEUP, INSTR_DONE;
    wire [11:0] NEXT_PC, IRQ_VECTOR, PUSH_PC, RETURN_PC;
    integer     n_mismatch = 0, n_tests = 0, k;
    always #12.5 REF_CLK = ~REF_CLK;
    timer_match_interrupt_wakeup timer_match_interrupt_wakeup_i
        (.*, .CALL_PUSH(1'b0), .RET_POP(1'b0));
    cpu_seq_model cpu_seq_model_i
        (.clk(REF_CLK), .run(run), .at_boundary(INSTR_DONE), .pc_r(NEXT_PC));
    task chk(input [31:0] g, e);
    begin
        n_tests = n_tests + 1;
        if (g !== e)
        begin
            n_mismatch = n_mismatch + 1;
            $display("unexpected at %0t: %h not %h", $time, g, e);
        end
    end
    endtask
    task summarize;
    begin
        $display("mismatches %0d of %0d", n_mismatch, n_tests);
        if (n_mismatch == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    end
    endtask
    // idle edge first: no signal set twice in one step
    task bus(input w, input [7:0] a, input [31:0] d, input [31:0] e);
    begin
        @(posedge REF_CLK);
        PSEL <= 1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge REF_CLK);
        PENABLE <= 1;
        k = 0;
        do
        begin
            @(posedge REF_CLK);
            k = k + 1;
        end
        while (PREADY !== 1'b1 && k < 20);
        rdat = PRDATA;
        err = PSLVERR;
        PSEL <= 0;
        PENABLE <= 0;
        chk(k < 20, 1);
        if (k >= 20)
            summarize;
        if (!w)
            chk(rdat, e);
    end
    endtask
    task mt(input p, input e);
    begin
        @(posedge REF_CLK);
        MATCH_A <= !p;
        MATCH_P <= p;
        @(posedge REF_CLK);
        MATCH_A <= 0;
        MATCH_P <= 0;
        #1 chk(WAKEUP, e);
    end
    endtask
    initial
    begin
        repeat (10) @(posedge REF_CLK);
        RST_N <= 1;
        repeat (2) @(posedge REF_CLK);
        bus(0, 8'h00, 0, 0);
        bus(0, 8'h0C, 0, 32'h8);
        bus(0, 8'h10, 0, 0);
        chk(err, 1);
        mt(0, 1);
        mt(0, 0);
        bus(0, 8'h04, 0, 32'h5);
        bus(1, 8'h04, 0, 0);
        mt(1, 1);
        run <= 1;
        bus(1, 8'h00, 32'hF, 0);
        k = 0;
        do
        begin
            @(negedge REF_CLK);
            k = k + 1;
        end
        while (IRQ_CALL !== 1'b1 && k < 20);
        pc = NEXT_PC;
        chk(k < 20, 1);
        if (k >= 20)
            summarize;
        bus(0, 8'h00, 0, 32'hE);
        bus(0, 8'h04, 0, 32'h2);
        chk(RETURN_PC, pc);
        chk(STACK_FULL, 0);
        @(posedge REF_CLK);
        RETURN_FROM_IRQ <= 1;
        @(posedge REF_CLK);
        RETURN_FROM_IRQ <= 0;
        bus(0, 8'h00, 0, 32'hF);
        summarize;
    end
endmodule
bind timer_match_interrupt_wakeup tmiw_chk tmiw_chk_i (.*);
